/* cdu_top.sv */
/*
  Two-channel 10-bit current DAC control: Wishbone register slave, staging
  registers, update source selection, pin takeover, bias request, reset persistence.
  Assumes rstn is the power-on / supply-monitor reset, warmReset a synchronous
  level for every other reset source, and all inputs synchronous to clock.
*/
// Local design decisions: the address map and register access over Wishbone.
`default_nettype none
// Overview of operation
// [RULE1] two independent 10-bit current DACs, full scale 0.5, 1 or 2 mA
// [RULE2] enable low: pin is ordinary GPIO under port control
// [RULE3] enable high: drivers and pull-up off, pin joined to DAC output
// [RULE4] any enabled DAC turns on the bias generator automatically
// [RULE5] code 111 (default) updates output at once on high-byte write
// [RULE6] in on-demand mode a low-byte write only stages
// [RULE7] software writes low byte first, then high byte, for 10 bits
// [RULE8] for 8-bit use, preset low byte once, then write high byte only
// [RULE9] codes 000-011 stage both bytes, load on selected timer overflow
// [RULE10] codes 100-110 stage both bytes until the strobe edge
// [RULE11] a qualifying strobe edge copies staged bytes into the output latch
// [RULE12] by default any reset source disables both DACs
// [RULE13] persist set: enable and output word survive all but power-on resets
// [RULE14] software makes the pin routing matrix skip the DAC output pin
// [RULE15] codes 000-011 pick timers 0-3; second DAC code 001 picks timer 5
// [RULE16] 100 rising, 101 falling, 110 either edge, 111 high-byte write
// [RULE17] full scale 00 is 0.5 mA, 01 is 1 mA, 1x is 2 mA; reset 2 mA
// [RULE18] left-justified: bits 9..2 in high byte, 1..0 in low bits 7..6
// [RULE19] data register reads return the staged bytes
module cdu_top (
  input  wire logic                                  clock,
  input  wire logic                                  rstn,
  input  wire logic                                  warmReset,
  // classic Wishbone slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [7:0]                            wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  output logic                                       wb_ack_o,
  output logic [31:0]                                wb_dat_o,
  // update event sources
  input  wire logic [cdu_pkg::NUM_TIMERS-1:0]        timerOverflow,
  input  wire logic                                  extConvertStrobe,
  // normal port control for the two DAC pins
  input  wire logic [cdu_pkg::NUM_CH-1:0]            portOut,
  input  wire logic [cdu_pkg::NUM_CH-1:0]            portOe,
  input  wire logic [cdu_pkg::NUM_CH-1:0]            portPullup,
  output logic [cdu_pkg::NUM_CH-1:0]                 pinOut,
  output logic [cdu_pkg::NUM_CH-1:0]                 pinOe,
  output logic [cdu_pkg::NUM_CH-1:0]                 pinPullupEn,
  output logic [cdu_pkg::NUM_CH-1:0]                 analogConnect,
  // analog side
  output logic                                       biasEnable,
  output logic [cdu_pkg::NUM_CH-1:0]                 dacEnable,
  output logic [cdu_pkg::NUM_CH*cdu_pkg::WORD_W-1:0] dacWord,
  output logic [cdu_pkg::NUM_CH*3-1:0]               dacCurrentSel
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-hot current select {2 mA, 1 mA, 0.5 mA} [RULE17]
  function automatic logic [2:0] fullScaleDecode(input logic [1:0] code);
    logic [2:0] sel;
    sel = 3'h4;
    if (code == cdu_pkg::FS_HALF) begin
      sel = 3'h1;
    end else if (code == cdu_pkg::FS_ONE) begin
      sel = 3'h2;
    end
    return sel;
  endfunction

  // timer used by codes 000-011, channel dependent [RULE15]
  function automatic int unsigned timerIndex(input int unsigned ch, input logic [1:0] code);
    int unsigned idx;
    idx = int'(code);
    if ((ch == 1) && (code == 2'h1)) begin
      idx = cdu_pkg::ALT_TIMER;
    end
    return idx;
  endfunction

  // bus decode
  logic        reqActive;
  logic        mapped;
  logic        chSel;
  logic [1:0]  regSel;
  logic        busWrite;
  logic        laneWrite;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // strobe edge detection
  logic        strobePrev_r;
  logic        strobeRise;
  logic        strobeFall;

  // per-channel register state
  logic [7:0]                   ctrl_r   [cdu_pkg::NUM_CH];
  logic [7:0]                   dataH_r  [cdu_pkg::NUM_CH];
  logic [7:0]                   dataL_r  [cdu_pkg::NUM_CH];
  logic [cdu_pkg::WORD_W-1:0]   wordOut  [cdu_pkg::NUM_CH];
  logic [7:0]                   rdByte   [cdu_pkg::NUM_CH];
  logic [cdu_pkg::NUM_CH-1:0]   enBits;

  assign reqActive = wb_cyc_i && wb_stb_i;
  assign mapped    = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0);
  assign chSel     = wb_adr_i[4];
  assign regSel    = wb_adr_i[3:2];
  // writes take effect on the edge that also samples ack high
  assign busWrite  = reqActive && wb_we_i && ack_r && mapped;
  assign laneWrite = busWrite && wb_sel_i[0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= reqActive && !ack_r;
    end
  end

  assign wb_ack_o = ack_r;

  assign strobeRise = extConvertStrobe && !strobePrev_r;
  assign strobeFall = !extConvertStrobe && strobePrev_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strobePrev_r <= 1'b0;
    end else begin
      strobePrev_r <= extConvertStrobe;
    end
  end

  genvar g;
  generate
    for (g = 0; g < cdu_pkg::NUM_CH; g++) begin : gCh
      logic              chHit;
      logic              wrCtrl;
      logic              wrHigh;
      logic              wrLow;
      logic              persist;
      logic              timerHit;
      logic [7:0]        ctrl_nxt;
      cdu_pkg::cdu_upd_t updSource;

      assign chHit    = (chSel == 1'(g));
      assign wrCtrl   = laneWrite && chHit && (regSel == cdu_pkg::REG_CTRL);
      assign wrHigh   = laneWrite && chHit && (regSel == cdu_pkg::REG_DATAH);
      assign wrLow    = laneWrite && chHit && (regSel == cdu_pkg::REG_DATAL);
      assign persist  = ctrl_r[g][cdu_pkg::CTRL_RP_BIT];
      assign updSource = cdu_pkg::cdu_upd_t'(ctrl_r[g][cdu_pkg::CTRL_CM_LSB +: 3]);
      assign timerHit = timerOverflow[timerIndex(g, updSource[1:0])]; // [RULE15]
      assign ctrl_nxt = wb_dat_i[7:0] & cdu_pkg::CTRL_WMASK;

      // warm reset clears control unless persistent; persist bit itself only
      // falls with rstn or a control write, so control is kept whole while it is set
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          ctrl_r[g] <= cdu_pkg::CTRL_RESET; // [RULE12] [RULE17]
        end else if (warmReset) begin
          if (!persist) begin
            ctrl_r[g] <= cdu_pkg::CTRL_RESET; // [RULE12]
          end
        end else if (wrCtrl) begin
          ctrl_r[g] <= ctrl_nxt;
        end
      end

      // staging bytes: every write is held here; only a code 111 high-byte write also goes straight to the latch [RULE6] [RULE9] [RULE10]
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          dataH_r[g] <= cdu_pkg::DATA_RESET;
          dataL_r[g] <= cdu_pkg::DATA_RESET;
        end else if (warmReset) begin
          if (!persist) begin
            dataH_r[g] <= cdu_pkg::DATA_RESET;
            dataL_r[g] <= cdu_pkg::DATA_RESET;
          end
        end else begin
          if (wrHigh) begin
            dataH_r[g] <= wb_dat_i[7:0];
          end
          if (wrLow) begin
            dataL_r[g] <= wb_dat_i[7:0] & cdu_pkg::DATAL_MASK; // [RULE18]
          end
        end
      end

      cdu_latch uLatch (
        .clock      (clock),
        .rstn       (rstn),
        .warmReset  (warmReset),
        .keepOnWarm (persist), // [RULE13]
        .updSource  (updSource),
        .highWrite  (wrHigh),
        .highWrData (wb_dat_i[7:0]),
        .stagedHigh (dataH_r[g]),
        .stagedLow  (dataL_r[g]),
        .timerHit   (timerHit),
        .strobeRise (strobeRise),
        .strobeFall (strobeFall),
        .outWord    (wordOut[g])
      );

      assign enBits[g] = ctrl_r[g][cdu_pkg::CTRL_EN_BIT];

      // pin takeover: port control while disabled, analog output while enabled
      assign pinOut[g]        = enBits[g] ? 1'b0 : portOut[g];    // [RULE2] [RULE3]
      assign pinOe[g]         = enBits[g] ? 1'b0 : portOe[g];     // [RULE2] [RULE3]
      assign pinPullupEn[g]   = enBits[g] ? 1'b0 : portPullup[g]; // [RULE3]
      assign analogConnect[g] = enBits[g];                        // [RULE3]

      assign dacWord[g*cdu_pkg::WORD_W +: cdu_pkg::WORD_W] = wordOut[g]; // [RULE1]
      assign dacCurrentSel[g*3 +: 3] =
        fullScaleDecode(ctrl_r[g][cdu_pkg::CTRL_FS_LSB +: 2]); // [RULE1] [RULE17]

      // reads show staged bytes, the word register shows the latch [RULE19]
      assign rdByte[g] = (regSel == cdu_pkg::REG_CTRL)  ? ctrl_r[g] :
                         (regSel == cdu_pkg::REG_DATAH) ? dataH_r[g] :
                         (regSel == cdu_pkg::REG_DATAL) ? dataL_r[g] :
                         wordOut[g][9:2];
    end
  endgenerate

  assign dacEnable  = enBits;
  assign biasEnable = |enBits; // [RULE4]

  // word register returns the latch in the low 10 bits, right aligned
  assign rdata_nxt = !mapped ? 32'h0000_0000 :
                     (regSel == cdu_pkg::REG_WORD) ?
                       {22'h00_0000, (chSel ? wordOut[1] : wordOut[0])} :
                       {24'h00_0000, (chSel ? rdByte[1] : rdByte[0])};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (reqActive && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_dat_o = rdata_r;
endmodule // cdu_top
`default_nettype wire

/* cdu_pkg.sv */
/*
  Constants and types for the two-channel current DAC update control.
  Assumes a 32-bit classic Wishbone register bus and 8-bit control/data registers.
*/
`default_nettype none
package cdu_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // channel count, data width and timer count
  localparam int unsigned NUM_CH     = 2;
  localparam int unsigned WORD_W     = 10;
  localparam int unsigned NUM_TIMERS = 6;

  // register map: adr[4] picks the channel, adr[3:2] picks the register
  localparam logic [7:0] CH0_BASE  = 8'h00;
  localparam logic [7:0] CH1_BASE  = 8'h10;
  localparam logic [1:0] REG_CTRL  = 2'h0;
  localparam logic [1:0] REG_DATAH = 2'h1;
  localparam logic [1:0] REG_DATAL = 2'h2;
  localparam logic [1:0] REG_WORD  = 2'h3;

  // control register fields
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_CM_LSB = 4;
  localparam int unsigned CTRL_RP_BIT = 2;
  localparam int unsigned CTRL_FS_LSB = 0;
  localparam logic [7:0]  CTRL_WMASK  = 8'hF7;

  // reset values
  localparam logic [7:0]        CTRL_RESET = 8'h72;
  localparam logic [7:0]        DATA_RESET = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;
  localparam logic [7:0]        DATAL_MASK = 8'hC0;

  // alternate timer used by code 001 on the second channel
  localparam int unsigned ALT_TIMER = 5;

  typedef enum logic [2:0] {
    UPD_TMR0  = 3'h0,
    UPD_TMR1  = 3'h1,
    UPD_TMR2  = 3'h2,
    UPD_TMR3  = 3'h3,
    UPD_RISE  = 3'h4,
    UPD_FALL  = 3'h5,
    UPD_ANY   = 3'h6,
    UPD_WRITE = 3'h7
  } cdu_upd_t;

  localparam logic [1:0] FS_HALF = 2'h0;
  localparam logic [1:0] FS_ONE  = 2'h1;
endpackage
`default_nettype wire

/* cdu_latch.sv */
/*
  One channel's output latch: loads the staged bytes on a timer or strobe event, or the written high byte and staged low byte on a high-byte write.
  Assumes pulses from the register block, timer overflow and strobe edge detector.
*/
`default_nettype none
module cdu_latch (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        warmReset,
  input  wire logic                        keepOnWarm,
  input  wire cdu_pkg::cdu_upd_t           updSource,
  input  wire logic                        highWrite,
  input  wire logic [7:0]                  highWrData,
  input  wire logic [7:0]                  stagedHigh,
  input  wire logic [7:0]                  stagedLow,
  input  wire logic                        timerHit,
  input  wire logic                        strobeRise,
  input  wire logic                        strobeFall,
  output logic [cdu_pkg::WORD_W-1:0]       outWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                         timerMode;
  logic                         strobeHit;
  logic                         writeHit;
  logic                         loadStaged;
  logic [cdu_pkg::WORD_W-1:0]   word_r;
  logic [cdu_pkg::WORD_W-1:0]   word_nxt;

  assign timerMode  = (updSource == cdu_pkg::UPD_TMR0) || (updSource == cdu_pkg::UPD_TMR1) ||
                      (updSource == cdu_pkg::UPD_TMR2) || (updSource == cdu_pkg::UPD_TMR3);
  // edge choice per code: rising, falling or either [RULE16]
  assign strobeHit  = ((updSource == cdu_pkg::UPD_RISE) && strobeRise) ||
                      ((updSource == cdu_pkg::UPD_FALL) && strobeFall) ||
                      ((updSource == cdu_pkg::UPD_ANY)  && (strobeRise || strobeFall)); // [RULE10]
  // immediate load on a high-byte write, low byte taken from staging [RULE5] [RULE6]
  assign writeHit   = (updSource == cdu_pkg::UPD_WRITE) && highWrite;
  assign loadStaged = (timerMode && timerHit) || strobeHit; // [RULE9] [RULE11]

  // left-justified word: high byte is bits 9..2, low byte bits 7..6 are 1..0 [RULE18]
  assign word_nxt = writeHit   ? {highWrData, stagedLow[7:6]} :
                    loadStaged ? {stagedHigh, stagedLow[7:6]} : word_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_r <= cdu_pkg::WORD_RESET;
    end else if (warmReset && !keepOnWarm) begin
      word_r <= cdu_pkg::WORD_RESET; // [RULE12]
    end else if (!warmReset) begin
      word_r <= word_nxt;
    end
  end

  assign outWord = word_r; // word kept through warm reset when persistent [RULE13]
endmodule // cdu_latch
`default_nettype wire

/* cdu_top_monitor.sv */
/* port assertions for the two-channel DAC update control
   bound into cdu_top; single clock, rstn async active low */
`default_nettype none
module cdu_top_monitor (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        warmReset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [5:0]  timerOverflow,
  input wire logic        extConvertStrobe,
  input wire logic [1:0]  portOut,
  input wire logic [1:0]  portOe,
  input wire logic [1:0]  portPullup,
  input wire logic [1:0]  pinOut,
  input wire logic [1:0]  pinOe,
  input wire logic [1:0]  pinPullupEn,
  input wire logic [1:0]  analogConnect,
  input wire logic        biasEnable,
  input wire logic [1:0]  dacEnable,
  input wire logic [19:0] dacWord,
  input wire logic [5:0]  dacCurrentSel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  a_pin_taken: assert property (dacEnable[0] |-> !pinOut[0] && !pinOe[0] && !pinPullupEn[0] && analogConnect[0])
    else $error("enabled pin still driven");
  a_pin_taken_b: assert property (dacEnable[1] |-> !pinOut[1] && !pinOe[1] && !pinPullupEn[1] && analogConnect[1])
    else $error("enabled second pin still driven");
  a_pin_gpio: assert property (!dacEnable[1] |-> pinOut[1] == portOut[1] && pinOe[1] == portOe[1] && pinPullupEn[1] == portPullup[1] && !analogConnect[1])
    else $error("disabled pin not under port control");
  a_pin_gpio_a: assert property (!dacEnable[0] |-> pinOut[0] == portOut[0] && pinOe[0] == portOe[0] && pinPullupEn[0] == portPullup[0] && !analogConnect[0])
    else $error("disabled first pin not under port control");
  a_bias_follow: assert property (biasEnable == (dacEnable[0] || dacEnable[1]))
    else $error("bias does not follow enables");
  a_fs_onehot: assert property (dacCurrentSel[2:0] inside {3'h1, 3'h2, 3'h4} && dacCurrentSel[5:3] inside {3'h1, 3'h2, 3'h4})
    else $error("full scale select not one-hot");
  a_word_cause: assert property ($changed(dacWord) |-> $past(wb_ack_o && wb_we_i) || $past(|timerOverflow) || ($past(extConvertStrobe) != $past(extConvertStrobe, 2)) || $past(warmReset))
    else $error("output word changed without update event");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:5] != 3'h0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_read_narrow: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0)
    else $error("read data wider than register");
  a_warm_keep: assert property (warmReset && dacEnable[0] |=> !dacEnable[0] || $stable(dacWord[9:0]))
    else $error("kept channel lost its word on warm reset");
endmodule // cdu_top_monitor
bind cdu_top cdu_top_monitor i_mon (.clock(clock), .rstn(rstn), .warmReset(warmReset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .timerOverflow(timerOverflow),
  .extConvertStrobe(extConvertStrobe), .portOut(portOut), .portOe(portOe),
  .portPullup(portPullup), .pinOut(pinOut),
  .pinOe(pinOe), .pinPullupEn(pinPullupEn), .analogConnect(analogConnect),
  .biasEnable(biasEnable), .dacEnable(dacEnable), .dacWord(dacWord),
  .dacCurrentSel(dacCurrentSel));
`default_nettype wire

/* cdu_event_src.sv */
/* update event sources: six timers and the conversion strobe pin
   a rise on a fire bit gives one overflow pulse; strobe follows its request */
`default_nettype none
module cdu_event_src (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [5:0] fire,
  input  wire logic       strobeReq,
  output logic [5:0]      timerOverflow,
  output logic            extConvertStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] fireD_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fireD_r <= 6'h00;
      timerOverflow <= 6'h00;
      extConvertStrobe <= 1'b0;
    end else begin
      fireD_r <= fire;
      timerOverflow <= fire & ~fireD_r;
      extConvertStrobe <= strobeReq;
    end
  end
endmodule // cdu_event_src
`default_nettype wire

/* cdu_top_bench.sv */
/* self-checking bench for cdu_top over classic Wishbone
   assumes cdu_top, cdu_event_src and the bound monitor */
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module cdu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rstn, warmReset, cyc, stb, we, ack, strobeReq, strobe, bias;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, datO, rdat;
  logic [5:0]  fire, tmr, curSel;
  logic [1:0]  pOut, pOe, pPull, pinOut, pinOe, pinPull, aConn, dEn;
  logic [19:0] dWord;
  logic [9:0]  expW;
  int          bad_count, check_count;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  cdu_event_src i_src (.clock(clock), .rstn(rstn), .fire(fire), .strobeReq(strobeReq),
    .timerOverflow(tmr), .extConvertStrobe(strobe));
  cdu_top i_dut (.clock(clock), .rstn(rstn), .warmReset(warmReset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(datO), .timerOverflow(tmr), .extConvertStrobe(strobe),
    .portOut(pOut), .portOe(pOe), .portPullup(pPull), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullupEn(pinPull), .analogConnect(aConn), .biasEnable(bias), .dacEnable(dEn),
    .dacWord(dWord), .dacCurrentSel(curSel));
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      close_out();
    end
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK(rdat, e)
  endtask
  task automatic pulse(input logic [5:0] m);
    fire <= m;
    repeat (3) @(posedge clock);
    fire <= 6'h00;
    repeat (3) @(posedge clock);
  endtask
  task automatic strb(input logic v);
    strobeReq <= v;
    repeat (4) @(posedge clock);
  endtask
  initial begin
    {rstn, warmReset, cyc, stb, we, strobeReq, adr, dat, fire} = '0;
    sel = 4'h1;
    {pOut, pOe, pPull} = 6'h3F; // routing matrix skips DAC pins: port latches only
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rchk(8'h00, 32'h72);
    rchk(8'h40, 32'h0);
    `CHK(curSel, 6'h24)
    `CHK(pinOe, pOe)
    `CHK({pinOut, pinPull}, 4'hF)
    expW = 10'h000;
    for (int c = 0; c < 7; c++) begin
      xfer(8'h00, 1'b1, 8'h80 | (8'(c) << 4));
      xfer(8'h08, 1'b1, 8'h40);
      xfer(8'h04, 1'b1, 8'h10 + 8'(c));
      pulse((c < 4) ? ~(6'h01 << c) : 6'h3F);
      `CHK(dWord[9:0], expW)
      if (c < 4) pulse(6'h01 << c);
      else strb(c != 5);
      expW = {8'h10 + 8'(c), 2'b01};
      `CHK(dWord[9:0], expW)
      rchk(8'h0C, {22'h0, expW});
    end
    xfer(8'h00, 1'b1, 8'hF0);
    `CHK(curSel[2:0], 3'h1)
    `CHK({bias, pinOe[0], aConn[0]}, 3'b101)
    `CHK({pinOut[0], pinPull[0]}, 2'b00)
    xfer(8'h08, 1'b1, 8'hFF);
    `CHK(dWord[9:0], expW)
    rchk(8'h08, 32'hC0);
    xfer(8'h04, 1'b1, 8'h5A);
    `CHK(dWord[9:0], 10'h16B)
    xfer(8'h08, 1'b1, 8'h00);
    xfer(8'h04, 1'b1, 8'hA5);
    `CHK(dWord[9:0], 10'h294)
    sel <= 4'h0;
    xfer(8'h04, 1'b1, 8'h3C);
    sel <= 4'h1;
    `CHK(dWord[9:0], 10'h294)
    rchk(8'h04, 32'hA5);
    xfer(8'h10, 1'b1, 8'h99);
    rchk(8'h10, 32'h91);
    `CHK({curSel[5:3], pinOe[1]}, 4'h4)
    xfer(8'h18, 1'b1, 8'hFF);
    xfer(8'h14, 1'b1, 8'h80);
    pulse(6'h02);
    `CHK(dWord[19:10], 10'h000)
    rchk(8'h14, 32'h80);
    pulse(6'h20);
    `CHK(dWord[19:10], 10'h203)
    xfer(8'h00, 1'b1, 8'hF4);
    warmReset <= 1'b1;
    @(posedge clock);
    warmReset <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(dEn, 2'b01)
    `CHK(dWord, {10'h000, 10'h294})
    rchk(8'h10, 32'h72);
    `CHK(pinOe[1], pOe[1])
    `CHK(pinOut[1], pOut[1])
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    `CHK(dEn, 2'b00)
    rchk(8'h00, 32'h72);
    close_out();
  end
endmodule // cdu_top_bench
`default_nettype wire
